// ===== logic/sram_host_pkg.sv
package sram_host_pkg;
   // Geometry
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   // Clock
   localparam int CLK_PERIOD_NS = 20;
   // Timing of the fastest grade, in ns
   localparam int WRITE_WINDOW_WIDTH_NS = 60;
   localparam int SELECT_TO_WRITE_END_NS = 80;
   localparam int ADDR_SETUP_TO_WINDOW_NS = 0;
   localparam int DATA_OVERLAP_TIME_NS = 40;
   localparam int ADDR_ACCESS_TIME_NS = 100;
   localparam int READ_PERIOD_NS = 100;
   // Least times round up
   localparam int WRITE_CYC = (WRITE_WINDOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEL_CYC = (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DATA_CYC = (DATA_OVERLAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ADDR_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (READ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Write hold covers window and select time
   localparam int WR_HOLD_CYC = (SEL_CYC > WRITE_CYC) ? SEL_CYC : WRITE_CYC;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_HOLD_CYC - 1);
   // Two spare cycles keep the sample past the access time through the synchroniser
   localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(ACCESS_CYC + 2);
   localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(READ_CYC - 1);
endpackage

// ===== logic/sram_host.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module sram_host #(
   parameter int ADDR_W = sram_host_pkg::ADDR_W,
   parameter int DATA_W = sram_host_pkg::DATA_W
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // User request
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic [DATA_W-1:0] RD_DATA,
   output logic RD_VALID,
   // Retention request
   input wire logic RETAIN,
   output logic RETAINED,
   // Memory pins
   output logic [ADDR_W-1:0] MEM_ADDR,
   output logic MEM_SELECT_LOW_ACTIVE_N,
   output logic MEM_SELECT_HIGH_ACTIVE,
   output logic MEM_WRITE_N,
   output logic MEM_OUTPUT_GATE_N,
   input wire logic [DATA_W-1:0] MEM_DATA_IN,
   output logic [DATA_W-1:0] MEM_DATA_OUT,
   output logic MEM_DATA_OE
);
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_WRITE = 5'h02,
      ST_READ = 5'h04,
      ST_RETAIN = 5'h08,
      ST_RECOVER = 5'h10
   } state_type;

   typedef struct packed {
      state_type st;
      logic [sram_host_pkg::CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic cs_n;
      logic cs2;
      logic we_n;
      logic oe_n;
      logic doe;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic [DATA_W-1:0] sync1;
      logic [DATA_W-1:0] sync2;
   } regs_type;

   regs_type q_r;
   regs_type q_nxt;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      q_nxt = q_r;
      q_nxt.rvalid = 1'b0;
      // Read data is asynchronous to CLK, so it is resynchronised
      q_nxt.sync1 = MEM_DATA_IN;
      q_nxt.sync2 = q_r.sync1;
      unique case (q_r.st)
         ST_IDLE: begin
            if (RETAIN) begin
               // Low select off, high select kept railed low
               q_nxt.cs_n = 1'b1;
               q_nxt.cs2 = 1'b0;
               q_nxt.we_n = 1'b1;
               q_nxt.oe_n = 1'b1;
               q_nxt.doe = 1'b0;
               q_nxt.st = ST_RETAIN;
            end else if (REQ_VALID && REQ_READY && REQ_WRITE) begin
               // All pins change in one edge
               q_nxt.addr = REQ_ADDR;
               q_nxt.wdata = REQ_WDATA;
               q_nxt.cs_n = 1'b0;
               q_nxt.cs2 = 1'b1;
               q_nxt.we_n = 1'b0;
               // Output gate high keeps the device off the data lines
               q_nxt.oe_n = 1'b1;
               q_nxt.doe = 1'b1;
               q_nxt.cnt = sram_host_pkg::WR_CNT;
               q_nxt.st = ST_WRITE;
            end else if (REQ_VALID && REQ_READY) begin
               q_nxt.addr = REQ_ADDR;
               q_nxt.cs_n = 1'b0;
               q_nxt.cs2 = 1'b1;
               q_nxt.we_n = 1'b1;
               q_nxt.oe_n = 1'b0;
               q_nxt.doe = 1'b0;
               q_nxt.cnt = sram_host_pkg::RD_CNT;
               q_nxt.st = ST_READ;
            end
         end
         ST_WRITE: begin
            // Window and selects held long enough
            if (q_r.cnt == '0) begin
               // Strobe rises first; data held one more cycle
               q_nxt.we_n = 1'b1;
               q_nxt.cs_n = 1'b1;
               q_nxt.cs2 = 1'b0;
               q_nxt.st = ST_IDLE;
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end
         ST_READ: begin
            // Access time plus two synchroniser stages
            if (q_r.cnt == '0) begin
               q_nxt.rdata = q_r.sync2;
               q_nxt.rvalid = 1'b1;
               q_nxt.cs_n = 1'b1;
               q_nxt.cs2 = 1'b0;
               q_nxt.oe_n = 1'b1;
               q_nxt.st = ST_IDLE;
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end
         ST_RETAIN: begin
            if (!RETAIN) begin
               q_nxt.cnt = sram_host_pkg::REC_CNT;
               q_nxt.st = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            // One read period before the next access
            if (q_r.cnt == '0) begin
               q_nxt.st = ST_IDLE;
            end else begin
               q_nxt.cnt = q_r.cnt - 1'b1;
            end
         end
         default: begin
            q_nxt.st = ST_IDLE;
         end
      endcase
      // Write data is released one cycle after the window closes; ready stays low meanwhile
      if (q_r.st == ST_IDLE && q_r.doe) begin
         q_nxt.doe = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         q_r <= '{st: ST_IDLE, cnt: '0, addr: '0, wdata: '0, cs_n: 1'b1, cs2: 1'b0,
                  we_n: 1'b1, oe_n: 1'b1, doe: 1'b0, rdata: '0, rvalid: 1'b0,
                  sync1: '0, sync2: '0};
      end else begin
         q_r <= q_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Ready waits for the previous write data to be released
   assign REQ_READY = (q_r.st == ST_IDLE) && !q_r.doe && !RETAIN;
   assign RD_DATA = q_r.rdata;
   assign RD_VALID = q_r.rvalid;
   assign RETAINED = (q_r.st == ST_RETAIN);
   assign MEM_ADDR = q_r.addr;
   assign MEM_SELECT_LOW_ACTIVE_N = q_r.cs_n;
   assign MEM_SELECT_HIGH_ACTIVE = q_r.cs2;
   assign MEM_WRITE_N = q_r.we_n;
   assign MEM_OUTPUT_GATE_N = q_r.oe_n;
   assign MEM_DATA_OUT = q_r.wdata;
   assign MEM_DATA_OE = q_r.doe;
endmodule

// ===== verif/sram_host_sva.sv
`timescale 1ns/100ps
module sram_host_sva #(parameter int ADDR_W = sram_host_pkg::ADDR_W, parameter int DATA_W = sram_host_pkg::DATA_W) (
   // Clock, reset and user side
   input wire logic CLK, RESET_N, REQ_VALID, REQ_WRITE, REQ_READY, RD_VALID, RETAINED,
   // Memory pins
   input wire logic [ADDR_W-1:0] MEM_ADDR,
   input wire logic MEM_SELECT_LOW_ACTIVE_N, MEM_SELECT_HIGH_ACTIVE, MEM_WRITE_N, MEM_OUTPUT_GATE_N, MEM_DATA_OE,
   input wire logic [DATA_W-1:0] MEM_DATA_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire sel = !MEM_SELECT_LOW_ACTIVE_N && MEM_SELECT_HIGH_ACTIVE;
   sequence take_wr; REQ_VALID && REQ_READY && REQ_WRITE; endsequence
   sequence take_rd; REQ_VALID && REQ_READY && !REQ_WRITE; endsequence
   a_write_window: assert property (take_wr |=> (sel && !MEM_WRITE_N)[*4] ##1 (!sel && MEM_WRITE_N))
      else $error("write window length wrong");
   a_write_data: assert property (take_wr |=> ##1 (MEM_DATA_OE && $stable(MEM_DATA_OUT))[*4])
      else $error("write data moved in window");
   a_read_strobe: assert property (take_rd |=> (sel && MEM_WRITE_N && !MEM_OUTPUT_GATE_N)[*8])
      else $error("read strobes wrong");
   a_read_answer: assert property (take_rd |-> ##9 RD_VALID)
      else $error("read answer late");
   a_no_clash: assert property (!MEM_OUTPUT_GATE_N |-> !MEM_DATA_OE)
      else $error("host drives against device");
   a_addr_steady: assert property (!MEM_WRITE_N && !$past(MEM_WRITE_N) |-> $stable(MEM_ADDR))
      else $error("address moved in window");
   a_retain_rail: assert property (RETAINED |-> MEM_SELECT_LOW_ACTIVE_N && !MEM_SELECT_HIGH_ACTIVE)
      else $error("retention selects wrong");
   a_retain_recover: assert property ($fell(RETAINED) |-> !REQ_READY[*5])
      else $error("recovery too short");
endmodule
bind sram_host sram_host_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) sram_host_sva_i (.*);

// ===== verif/sram_device_model.sv
`timescale 1ns/100ps
module sram_device_model #(parameter int ACC_NS = 60) (
   input wire logic [12:0] addr,
   input wire logic sel_n, sel, we_n, oe_n,
   input wire logic [7:0] din,
   output logic [7:0] dout
);
   logic [7:0] mem [0:8191];
   logic [7:0] last = 8'h00;
   wire act = !sel_n && sel;
   wire drive = act && we_n && !oe_n;
   // Cell takes the data as the window closes, when address and data are settled
   wire wr = act && !we_n;
   always @(negedge wr) mem[addr] = din;
   // Release is immediate, turn-on waits, so released lines never look valid
   always @(addr or drive) begin
      dout = ~last;
      if (drive) begin
         #(ACC_NS);
         if (drive) begin
            dout = mem[addr];
            last = dout;
         end
      end
   end
endmodule

// ===== verif/sram_host_bench.sv
`timescale 1ns/100ps
module sram_host_bench;
   logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, retain = 0;
   logic [12:0] req_addr = '0, mem_addr;
   logic [7:0] req_wdata = '0, rd_data, din, dout;
   logic ready, rd_valid, retained, sel_n, sel, we_n, oe_n, doe;
   int err_total = 0, comparisons = 0, seed;
   logic [7:0] ref_mem [int];
   logic [7:0] exp_q [$];
   logic [12:0] addrs [$];
   always #10 clk = ~clk;
   sram_host sram_host_i (.CLK(clk), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .RETAIN(retain), .RETAINED(retained), .MEM_ADDR(mem_addr), .MEM_SELECT_LOW_ACTIVE_N(sel_n),
      .MEM_SELECT_HIGH_ACTIVE(sel), .MEM_WRITE_N(we_n), .MEM_OUTPUT_GATE_N(oe_n), .MEM_DATA_IN(din),
      .MEM_DATA_OUT(dout), .MEM_DATA_OE(doe));
   // Slowest access of the fastest grade; released host lines read inverted so a missing drive shows
   sram_device_model #(.ACC_NS(100)) sram_device_model_i (.addr(mem_addr), .sel_n(sel_n), .sel(sel), .we_n(we_n),
      .oe_n(oe_n), .din(doe ? dout : ~dout), .dout(din));
   ////////////////////////////////////////////////////////////////////////
   task check(input string what, input logic [7:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task req(input bit w, input logic [12:0] a, input logic [7:0] d);
      for (int i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk);
      req_valid = 1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge clk);
      req_valid = 0;
      if (w) begin
         ref_mem[a] = d;
         addrs.push_back(a);
      end else exp_q.push_back(ref_mem[a]);
   endtask
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each read result is checked against the reference in arrival order
   always @(negedge clk) if (rd_valid === 1'b1) check("read data", exp_q.pop_front(), rd_data);
   ////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(7);
      repeat (16) @(negedge clk);
      reset_n = 1;
      req(1, 13'h0000, 8'hFF);
      req(1, 13'h1FFF, 8'h00);
      for (int i = 0; i < 12; i++) req(1, 13'($urandom), 8'($urandom));
      foreach (addrs[i]) req(0, addrs[i], 8'h00);
      repeat (8) @(negedge clk);
      $display("access test done");
      req_valid = 1;
      req_addr = 13'h0000;
      retain = 1;
      repeat (3) @(negedge clk);
      check("retained", 8'h01, {7'h00, retained});
      check("high select", 8'h00, {7'h00, sel});
      req_valid = 0;
      retain = 0;
      @(negedge clk);
      check("ready in recovery", 8'h00, {7'h00, ready});
      req(0, 13'h0000, 8'h00);
      repeat (10) @(negedge clk);
      check("reads pending", 8'h00, 8'(exp_q.size()));
      $display("retention test done");
      final_report;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      final_report;
   end
endmodule
